/* swk_defines.svh */
/*
  Constants for the sleep and wake-up controller: register offsets,
  field positions, reset values, commands and timing counts.
  Assumes inclusion by the package and the controller module only.
*/
// Functional notes
// - Executing the sleep instruction puts the device into power-down.
// - Sleep entry clears the running watchdog, clears power_down_flag, sets timeout_flag.
// - Sleep entry stops the main oscillator, so no phase clocks run.
// - Port pins keep their pre-sleep drive state while asleep.
// - Wake sources: master clear, watchdog time-out, or an enabled interrupt.
// - Master clear during sleep fully resets; other sources resume execution.
// - power_down_flag is set at power-up and cleared by sleep.
// - A watchdog time-out clears timeout_flag, also when it wakes the device.
// - Only A/D completion on its RC clock may wake from peripherals.
// - During the sleep instruction the instruction at PC plus one is prefetched.
// - An interrupt wakes only if individually enabled, whatever global_irq_enable says.
// - With global_irq_enable clear, execution continues after the sleep instruction.
// - With global_irq_enable set, next instruction runs, then branch to vector.
// - An enabled flag already set makes sleep a no-operation, flags untouched.
// - An interrupt during or after sleep entry wakes at once after full entry.
// - power_down_flag stays set after a sleep turned into a no-operation.
// - Crystal modes wait 1024 oscillator periods on wake; internal RC does not.
// - Program memory reads out only while code protection is off.
// - Four ID words at 2000h-2003h, reachable only in program/verify mode.
// - In program mode clock pin clocks serial data on the data pin.
// - Program counter starts at zero; 6-bit command then 14 data bits.
// - Watchdog time-out resets when running, only wakes when asleep.
// - Any change on the three port-change pins sets port_change_flag.
`ifndef SWK_DEFINES_SVH
`define SWK_DEFINES_SVH

// Register offsets
`define SWK_REG_STATUS 4'h0
`define SWK_REG_INTCTL 4'h1
`define SWK_REG_WAKECFG 4'h2
`define SWK_REG_PERIPH 4'h3

// Field positions
`define SWK_ST_PD 3
`define SWK_ST_TO 4
`define SWK_IC_GIE 7
`define SWK_IC_EXT_EN 4
`define SWK_IC_PC_EN 3
`define SWK_IC_EXT_FLAG 1
`define SWK_IC_PC_FLAG 0
`define SWK_WC_WDT_EN 0
`define SWK_WC_OSC_LO 1
`define SWK_WC_ADC_RC 3
`define SWK_WC_MASTER_CLEAR_PIN_EN 4
`define SWK_WC_CPROT 5
`define SWK_WC_EDGE_RISE 6
`define SWK_PF_ADC_FLAG 0
`define SWK_PF_ADC_EN 1

// Reset values
`define SWK_RST_PD 1'b1
`define SWK_RST_TO 1'b1
`define SWK_RST_WDT_EN 1'b1
`define SWK_RST_MASTER_CLEAR_PIN_EN 1'b1

// Addresses
`define SWK_VECTOR_ADDR 14'h0004
`define SWK_ID_BASE 14'h2000

// Oscillator modes
`define SWK_OSC_INTERNAL_RC_OSC_MODE 2'h0

// Serial programming commands
`define SWK_CMD_LOAD_CFG 6'h00
`define SWK_CMD_LOAD 6'h02
`define SWK_CMD_READ 6'h04
`define SWK_CMD_INC 6'h06
`define SWK_CMD_BITS 4'h6
`define SWK_DATA_BITS 4'hE

// Timing
`define SWK_CLK_MHZ 10
`define SWK_WDT_TIME_US 18000
`define SWK_WDT_W 18
`define SWK_OST_PERIODS 1024
`define SWK_CLK_PER_OSC 1
`define SWK_OST_CYCLES (`SWK_OST_PERIODS * `SWK_CLK_PER_OSC)

`endif

/* swk_pkg.sv */
/*
  Types of the sleep and wake-up controller.
  Assumes the constants header is on the include path.
*/
`include "swk_defines.svh"

package swk_pkg;

  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_OST, ST_WAKE} swk_state_t;

  typedef enum logic [1:0] {SP_CMD, SP_LOAD, SP_READ} swk_sphase_t;

  typedef logic [`SWK_WDT_W-1:0] swk_wdt_t;
  typedef logic [10:0] swk_ost_t;
  typedef logic [13:0] swk_addr_t;
  typedef logic [13:0] swk_word_t;

  typedef struct packed {
    swk_state_t st;
    logic pd;
    logic to;
    logic global_irq_enable;
    logic ext_en;
    logic pc_en;
    logic ext_flag;
    logic pc_flag;
    logic adc_en;
    logic adc_flag;
    logic wdt_en;
    logic [1:0] osc_mode;
    logic adc_rc;
    logic master_clear_pin_en;
    logic cprot;
    logic edge_rise;
    logic ext_prev;
    logic [2:0] port_prev;
    swk_wdt_t wdt;
    swk_ost_t ost;
    logic irq_cause;
    logic [7:0] rdata;
    logic osc_run;
    logic sleeping;
    logic resume;
    logic vector;
    swk_addr_t branch;
    swk_addr_t fetch;
    logic dev_rst;
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
    logic prog;
    logic hv_prev;
    logic clk_prev;
    swk_sphase_t sphase;
    logic [3:0] scnt;
    swk_word_t sr;
    swk_addr_t pc;
    logic sd_out;
    logic sd_oe;
    swk_word_t pmem_wd;
    logic pmem_wr;
    logic [3:0][13:0] id;
  } swk_state_s_t;

endpackage

/* swk_sleep_wake.sv */
/*
  Sleep and wake-up controller with watchdog, wake-source capture,
  oscillator start-up wait, pin hold and serial program/verify engine.
  Assumes a core that pulses the sleep and watchdog-clear inputs, and
  that all inputs are synchronous to I_CLK_SYS, which never stops.
*/
`timescale 1ns/100ps
`include "swk_defines.svh"

module swk_sleep_wake #(
  parameter int WDT_CYCLES = `SWK_WDT_TIME_US * `SWK_CLK_MHZ
) (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  // Register port
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // Core side
  input wire logic I_SLEEP_EXEC,
  input wire logic I_WDT_CLR,
  input wire logic [13:0] I_PC,
  input wire logic [5:0] I_PIN_OUT,
  input wire logic [5:0] I_PIN_OE,
  output logic O_OSC_RUN,
  output logic O_SLEEPING,
  output logic O_RESUME,
  output logic O_VECTOR,
  output logic [13:0] O_BRANCH_ADDR,
  output logic [13:0] O_FETCH_ADDR,
  output logic O_DEV_RESET,
  output logic [5:0] O_PIN_OUT,
  output logic [5:0] O_PIN_OE,
  // Wake sources
  input wire logic I_EXT_IRQ,
  input wire logic [2:0] I_PORT_CHG,
  input wire logic I_ADC_DONE,
  input wire logic I_MASTER_CLEAR_PIN_N,
  // Serial programming
  input wire logic I_MASTER_CLEAR_PIN_HV,
  input wire logic I_PROG_CLK,
  input wire logic I_PROG_DATA,
  output logic O_PROG_DATA,
  output logic O_PROG_DATA_OE,
  output logic O_PROG_MODE,
  // Program memory
  input wire logic [13:0] I_PMEM_DATA,
  output logic [13:0] O_PMEM_ADDR,
  output logic [13:0] O_PMEM_WDATA,
  output logic O_PMEM_WR
);

  swk_pkg::swk_state_s_t s_reg;
  swk_pkg::swk_state_s_t s_next;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic irq_hit(input swk_pkg::swk_state_s_t s, input logic asleep);
    irq_hit = (s.ext_en & s.ext_flag) | (s.pc_en & s.pc_flag) |
              (s.adc_en & s.adc_flag & (s.adc_rc | ~asleep));
  endfunction

  function automatic logic is_id(input swk_pkg::swk_addr_t a);
    is_id = (a[13:2] == 12'(`SWK_ID_BASE >> 2));
  endfunction

  logic wdt_hit;
  logic master_clear_pin_act;
  logic ext_edge;
  logic sleep_go;
  swk_pkg::swk_state_t wake_st;
  swk_pkg::swk_word_t sh;

  assign wdt_hit = s_reg.wdt_en &&
                   (s_reg.wdt == swk_pkg::swk_wdt_t'(WDT_CYCLES - 1));
  assign master_clear_pin_act = s_reg.master_clear_pin_en && !I_MASTER_CLEAR_PIN_N;
  assign ext_edge = s_reg.edge_rise ? (I_EXT_IRQ & ~s_reg.ext_prev) :
                                      (~I_EXT_IRQ & s_reg.ext_prev);
  assign sleep_go = (s_reg.st == swk_pkg::ST_RUN) && I_SLEEP_EXEC && !s_reg.prog &&
                    !master_clear_pin_act && !wdt_hit && !irq_hit(s_reg, 1'b0);
  // Crystal modes wait for start-up, internal RC goes straight on
  assign wake_st = (s_reg.osc_mode == `SWK_OSC_INTERNAL_RC_OSC_MODE) ? swk_pkg::ST_WAKE :
                   swk_pkg::ST_OST;
  assign sh = {I_PROG_DATA, s_reg.sr[13:1]};

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.resume = 1'b0;
    s_next.vector = 1'b0;
    s_next.dev_rst = 1'b0;
    s_next.pmem_wr = 1'b0;
    s_next.ext_prev = I_EXT_IRQ;
    s_next.port_prev = I_PORT_CHG;

    // Register writes
    if (I_WR) begin
      case (I_ADDR)
        `SWK_REG_INTCTL: begin
          s_next.global_irq_enable = I_WDATA[`SWK_IC_GIE];
          s_next.ext_en = I_WDATA[`SWK_IC_EXT_EN];
          s_next.pc_en = I_WDATA[`SWK_IC_PC_EN];
          s_next.ext_flag = I_WDATA[`SWK_IC_EXT_FLAG];
          s_next.pc_flag = I_WDATA[`SWK_IC_PC_FLAG];
        end
        `SWK_REG_WAKECFG: begin
          s_next.wdt_en = I_WDATA[`SWK_WC_WDT_EN];
          s_next.osc_mode = I_WDATA[`SWK_WC_OSC_LO +: 2];
          s_next.adc_rc = I_WDATA[`SWK_WC_ADC_RC];
          s_next.master_clear_pin_en = I_WDATA[`SWK_WC_MASTER_CLEAR_PIN_EN];
          s_next.cprot = I_WDATA[`SWK_WC_CPROT];
          s_next.edge_rise = I_WDATA[`SWK_WC_EDGE_RISE];
        end
        `SWK_REG_PERIPH: begin
          s_next.adc_flag = I_WDATA[`SWK_PF_ADC_FLAG];
          s_next.adc_en = I_WDATA[`SWK_PF_ADC_EN];
        end
        default: begin
        end
      endcase
    end

    // Event capture in always-on logic, set wins over clear
    if (ext_edge) begin
      s_next.ext_flag = 1'b1;
    end
    if (I_PORT_CHG != s_reg.port_prev) begin
      s_next.pc_flag = 1'b1;
    end
    if (I_ADC_DONE) begin
      s_next.adc_flag = 1'b1;
    end

    // Register reads
    s_next.rdata = 8'h00;
    if (I_RD) begin
      case (I_ADDR)
        `SWK_REG_STATUS: begin
          s_next.rdata[`SWK_ST_PD] = s_reg.pd;
          s_next.rdata[`SWK_ST_TO] = s_reg.to;
        end
        `SWK_REG_INTCTL: begin
          s_next.rdata[`SWK_IC_GIE] = s_reg.global_irq_enable;
          s_next.rdata[`SWK_IC_EXT_EN] = s_reg.ext_en;
          s_next.rdata[`SWK_IC_PC_EN] = s_reg.pc_en;
          s_next.rdata[`SWK_IC_EXT_FLAG] = s_reg.ext_flag;
          s_next.rdata[`SWK_IC_PC_FLAG] = s_reg.pc_flag;
        end
        `SWK_REG_WAKECFG: begin
          s_next.rdata[`SWK_WC_WDT_EN] = s_reg.wdt_en;
          s_next.rdata[`SWK_WC_OSC_LO +: 2] = s_reg.osc_mode;
          s_next.rdata[`SWK_WC_ADC_RC] = s_reg.adc_rc;
          s_next.rdata[`SWK_WC_MASTER_CLEAR_PIN_EN] = s_reg.master_clear_pin_en;
          s_next.rdata[`SWK_WC_CPROT] = s_reg.cprot;
          s_next.rdata[`SWK_WC_EDGE_RISE] = s_reg.edge_rise;
        end
        `SWK_REG_PERIPH: begin
          s_next.rdata[`SWK_PF_ADC_FLAG] = s_reg.adc_flag;
          s_next.rdata[`SWK_PF_ADC_EN] = s_reg.adc_en;
        end
        default: begin
        end
      endcase
    end

    // Watchdog runs in every state
    if (!s_reg.wdt_en || wdt_hit) begin
      s_next.wdt = '0;
    end else begin
      s_next.wdt = s_reg.wdt + 1'b1;
    end
    if (I_WDT_CLR && s_reg.st == swk_pkg::ST_RUN) begin
      s_next.wdt = '0;
      s_next.pd = 1'b1;
      s_next.to = 1'b1;
    end

    // Power state
    case (s_reg.st)
      swk_pkg::ST_RUN: begin
        if (master_clear_pin_act) begin
          s_next.dev_rst = 1'b1;
          s_next.global_irq_enable = 1'b0;
        end else if (wdt_hit) begin
          s_next.dev_rst = 1'b1;
          s_next.global_irq_enable = 1'b0;
          s_next.to = 1'b0;
        end else if (sleep_go) begin
          s_next.st = swk_pkg::ST_SLEEP;
          s_next.wdt = '0;
          s_next.pd = 1'b0;
          s_next.to = 1'b1;
          s_next.fetch = I_PC + 1'b1;
        end
        // An already pending enabled interrupt leaves everything untouched
      end
      swk_pkg::ST_SLEEP: begin
        if (master_clear_pin_act) begin
          s_next.st = swk_pkg::ST_RUN;
          s_next.dev_rst = 1'b1;
          s_next.global_irq_enable = 1'b0;
        end else if (wdt_hit) begin
          s_next.to = 1'b0;
          s_next.irq_cause = 1'b0;
          s_next.st = wake_st;
        end else if (irq_hit(s_reg, 1'b1)) begin
          // Individual enables only, global enable ignored
          s_next.irq_cause = 1'b1;
          s_next.st = wake_st;
        end
      end
      swk_pkg::ST_OST: begin
        s_next.ost = s_reg.ost + 1'b1;
        if (master_clear_pin_act) begin
          s_next.st = swk_pkg::ST_RUN;
          s_next.dev_rst = 1'b1;
          s_next.global_irq_enable = 1'b0;
          s_next.ost = '0;
        end else if (s_reg.ost == swk_pkg::swk_ost_t'(`SWK_OST_CYCLES - 1)) begin
          s_next.st = swk_pkg::ST_WAKE;
          s_next.ost = '0;
        end
      end
      swk_pkg::ST_WAKE: begin
        s_next.st = swk_pkg::ST_RUN;
        s_next.resume = 1'b1;
        s_next.vector = s_reg.irq_cause & s_reg.global_irq_enable;
        s_next.branch = (s_reg.irq_cause & s_reg.global_irq_enable) ? `SWK_VECTOR_ADDR :
                        s_reg.fetch;
      end
      default: begin
        s_next.st = swk_pkg::ST_RUN;
      end
    endcase

    s_next.sleeping = (s_next.st == swk_pkg::ST_SLEEP);
    s_next.osc_run = (s_next.st != swk_pkg::ST_SLEEP);
    if (s_next.st == swk_pkg::ST_RUN) begin
      s_next.pin_out = I_PIN_OUT;
      s_next.pin_oe = I_PIN_OE;
    end

    // Serial program/verify engine
    s_next.hv_prev = I_MASTER_CLEAR_PIN_HV;
    s_next.clk_prev = I_PROG_CLK;
    if (!s_reg.prog) begin
      if (I_MASTER_CLEAR_PIN_HV && !s_reg.hv_prev && !I_PROG_CLK && !I_PROG_DATA) begin
        s_next.prog = 1'b1;
        s_next.pc = '0;
        s_next.sphase = swk_pkg::SP_CMD;
        s_next.scnt = '0;
      end
    end else if (!I_MASTER_CLEAR_PIN_HV) begin
      s_next.prog = 1'b0;
      s_next.sd_oe = 1'b0;
    end else if (I_PROG_CLK && !s_reg.clk_prev) begin
      // Rising edge of the programming clock
      case (s_reg.sphase)
        swk_pkg::SP_CMD: begin
          s_next.sd_oe = 1'b0;
          s_next.sr = sh;
          s_next.scnt = s_reg.scnt + 1'b1;
          if (s_reg.scnt == `SWK_CMD_BITS - 4'h1) begin
            s_next.scnt = '0;
            case (sh[13:8])
              `SWK_CMD_LOAD_CFG: begin
                s_next.pc = `SWK_ID_BASE;
              end
              `SWK_CMD_LOAD: begin
                s_next.sphase = swk_pkg::SP_LOAD;
              end
              `SWK_CMD_READ: begin
                s_next.sphase = swk_pkg::SP_READ;
                if (is_id(s_reg.pc)) begin
                  s_next.sr = s_reg.id[s_reg.pc[1:0]];
                end else if (s_reg.cprot) begin
                  s_next.sr = '0;
                end else begin
                  s_next.sr = I_PMEM_DATA;
                end
              end
              `SWK_CMD_INC: begin
                s_next.pc = s_reg.pc + 1'b1;
              end
              default: begin
              end
            endcase
          end
        end
        swk_pkg::SP_LOAD: begin
          s_next.sr = sh;
          s_next.scnt = s_reg.scnt + 1'b1;
          if (s_reg.scnt == `SWK_DATA_BITS - 4'h1) begin
            s_next.scnt = '0;
            s_next.sphase = swk_pkg::SP_CMD;
            if (is_id(s_reg.pc)) begin
              s_next.id[s_reg.pc[1:0]] = sh;
            end else begin
              s_next.pmem_wd = sh;
              s_next.pmem_wr = 1'b1;
            end
          end
        end
        swk_pkg::SP_READ: begin
          s_next.sd_oe = 1'b1;
          s_next.sd_out = s_reg.sr[0];
          s_next.sr = {1'b0, s_reg.sr[13:1]};
          s_next.scnt = s_reg.scnt + 1'b1;
          if (s_reg.scnt == `SWK_DATA_BITS - 4'h1) begin
            s_next.scnt = '0;
            s_next.sphase = swk_pkg::SP_CMD;
          end
        end
        default: begin
          s_next.sphase = swk_pkg::SP_CMD;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      s_reg <= '0;
      s_reg.pd <= `SWK_RST_PD;
      s_reg.to <= `SWK_RST_TO;
      s_reg.wdt_en <= `SWK_RST_WDT_EN;
      s_reg.master_clear_pin_en <= `SWK_RST_MASTER_CLEAR_PIN_EN;
      s_reg.osc_run <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign O_RDATA = s_reg.rdata;
  assign O_OSC_RUN = s_reg.osc_run;
  assign O_SLEEPING = s_reg.sleeping;
  assign O_RESUME = s_reg.resume;
  assign O_VECTOR = s_reg.vector;
  assign O_BRANCH_ADDR = s_reg.branch;
  assign O_FETCH_ADDR = s_reg.fetch;
  assign O_DEV_RESET = s_reg.dev_rst;
  assign O_PIN_OUT = s_reg.pin_out;
  assign O_PIN_OE = s_reg.pin_oe;
  assign O_PROG_DATA = s_reg.sd_out;
  assign O_PROG_DATA_OE = s_reg.sd_oe;
  assign O_PROG_MODE = s_reg.prog;
  assign O_PMEM_ADDR = s_reg.pc;
  assign O_PMEM_WDATA = s_reg.pmem_wd;
  assign O_PMEM_WR = s_reg.pmem_wr;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);

  a_sleep_flags: assert property (sleep_go |=> !O_RESUME && !s_reg.pd && s_reg.to &&
                                  O_SLEEPING)
    else $error("sleep entry flags wrong");
  a_sleep_nop: assert property ((s_reg.st == swk_pkg::ST_RUN) && I_SLEEP_EXEC &&
                                irq_hit(s_reg, 1'b0) && !I_WDT_CLR |=>
                                $stable(s_reg.pd) && !O_SLEEPING)
    else $error("sleep with pending irq not a nop");
  a_osc_off: assert property (O_SLEEPING |-> !O_OSC_RUN)
    else $error("oscillator running in sleep");
  a_pins_hold: assert property (O_SLEEPING && $past(O_SLEEPING) |-> $stable(O_PIN_OUT) &&
                                $stable(O_PIN_OE))
    else $error("pins changed in sleep");
  a_ost_wait: assert property ((s_reg.st == swk_pkg::ST_OST) && !master_clear_pin_act &&
                               (s_reg.ost != swk_pkg::swk_ost_t'(`SWK_OST_CYCLES - 1)) |=>
                               (s_reg.st == swk_pkg::ST_OST))
    else $error("start-up wait cut short");
  a_wdt_reset: assert property ((s_reg.st == swk_pkg::ST_RUN) && wdt_hit && !master_clear_pin_act |=>
                                O_DEV_RESET && !s_reg.to)
    else $error("watchdog reset missing");
  a_wdt_wake: assert property ((s_reg.st == swk_pkg::ST_SLEEP) && wdt_hit && !master_clear_pin_act |=>
                               !O_SLEEPING && !O_DEV_RESET && !s_reg.to)
    else $error("watchdog wake wrong");
  a_master_clear_pin_reset: assert property ((s_reg.st == swk_pkg::ST_SLEEP) && master_clear_pin_act |=>
                                 O_DEV_RESET && !O_SLEEPING)
    else $error("master clear did not reset");
  a_inline_wake: assert property (O_RESUME && !$past(s_reg.global_irq_enable) |-> !O_VECTOR &&
                                  O_BRANCH_ADDR == O_FETCH_ADDR)
    else $error("vector taken with global enable clear");
  a_vector_wake: assert property (O_VECTOR |-> O_RESUME &&
                                  O_BRANCH_ADDR == `SWK_VECTOR_ADDR)
    else $error("vector address wrong");
  a_port_change: assert property (I_PORT_CHG != s_reg.port_prev |=> s_reg.pc_flag)
    else $error("port change flag not set");
  a_prefetch: assert property (sleep_go |=> O_FETCH_ADDR == $past(I_PC) + 14'h0001)
    else $error("prefetch address wrong");

endmodule

/* swk_sleep_wake_tb.sv */
/*
  Self-checking testbench for the sleep and wake-up controller.
  Assumes swk_pkg.sv and swk_sleep_wake.sv are compiled before it.
*/
`timescale 1ns/100ps

module swk_sleep_wake_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic slp = 1'b0, wclr = 1'b0, ext = 1'b0, adc = 1'b0, master_clear_pin_n = 1'b1;
  logic hv = 1'b0, pclk = 1'b0, pdat = 1'b0;
  logic [2:0] pchg = 3'h0;
  logic [13:0] pc = 14'h0000, pmem = 14'h0000, got;
  logic [5:0] pin_o = 6'h00, pin_e = 6'h00;
  wire [7:0] rdata;
  wire osc, sleeping, resume, vect, dev_rst, pmode;
  wire [13:0] baddr, faddr, pm_addr, pm_wd;
  wire [5:0] opin, ooe;
  wire pd_o, pd_oe, pm_wr;
  logic [7:0] rd_q[$];
  logic [14:0] res_q[$];
  logic [13:0] wr_q[$];
  int bad_count = 0, comparisons = 0, seed = 32'h62E6, n;
  logic [13:0] id_val;

  always #50 clk = ~clk;

  swk_sleep_wake #(.WDT_CYCLES(64)) dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SLEEP_EXEC(slp),
    .I_WDT_CLR(wclr), .I_PC(pc), .I_PIN_OUT(pin_o), .I_PIN_OE(pin_e), .O_OSC_RUN(osc),
    .O_SLEEPING(sleeping), .O_RESUME(resume), .O_VECTOR(vect), .O_BRANCH_ADDR(baddr),
    .O_FETCH_ADDR(faddr), .O_DEV_RESET(dev_rst), .O_PIN_OUT(opin), .O_PIN_OE(ooe),
    .I_EXT_IRQ(ext), .I_PORT_CHG(pchg), .I_ADC_DONE(adc), .I_MASTER_CLEAR_PIN_N(master_clear_pin_n),
    .I_MASTER_CLEAR_PIN_HV(hv), .I_PROG_CLK(pclk), .I_PROG_DATA(pdat), .O_PROG_DATA(pd_o),
    .O_PROG_DATA_OE(pd_oe), .O_PROG_MODE(pmode), .I_PMEM_DATA(pmem), .O_PMEM_ADDR(pm_addr),
    .O_PMEM_WDATA(pm_wd), .O_PMEM_WR(pm_wr));

  // ----------------------------------------
  // Checking and verdict
  // ----------------------------------------
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    comparisons++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      bad_count++;
    end
  endtask

  task automatic stop_test();
    check("notes left", 16'h0000, 16'(rd_q.size() + res_q.size() + wr_q.size()));
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Monitor takes the oldest note whenever a result appears
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) begin
      if (rd_q.size() == 0) check("read note", 16'h0001, 16'h0000);
      else check("read data", {8'h00, rd_q.pop_front()}, {8'h00, rdata});
    end
    if (resume === 1'b1) begin
      if (res_q.size() == 0) check("resume note", 16'h0001, 16'h0000);
      else check("resume", {1'b0, res_q.pop_front()}, {1'b0, vect, baddr});
    end
    if (pm_wr === 1'b1) begin
      if (wr_q.size() == 0) check("write note", 16'h0001, 16'h0000);
      else check("pmem write", {2'h0, wr_q.pop_front()}, {2'h0, pm_wd});
    end
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    rd_q.push_back(exp);
    @(posedge clk) rd <= 1'b0;
  endtask

  function automatic logic sig(input int w);
    return (w == 0) ? resume : (w == 1) ? dev_rst : sleeping;
  endfunction

  task automatic wait_sig(input int w, input int lim, output int c);
    c = 0;
    do begin
      @(posedge clk) #1;
      c++;
    end while (sig(w) !== 1'b1 && c < lim);
    if (sig(w) !== 1'b1) begin
      check("wait bound", 16'h0001, 16'h0000);
      stop_test();
    end
  endtask

  task automatic sleep_now();
    @(posedge clk) begin slp <= 1'b1; pc <= 14'($random(seed)) & 14'h1FFF; end
    @(posedge clk) slp <= 1'b0;
  endtask

  task automatic pbits(input logic [13:0] v, input int nb, output logic [13:0] r);
    r = 14'h0000;
    for (int i = 0; i < nb; i++) begin
      @(posedge clk) begin pclk <= 1'b0; pdat <= v[i]; end
      @(posedge clk) pclk <= 1'b1;
      tick(2);
      #1 r[i] = pd_o;
    end
  endtask

  task automatic prog_enter();
    @(posedge clk) begin hv <= 1'b0; pclk <= 1'b0; pdat <= 1'b0; end
    tick(2);
    @(posedge clk) hv <= 1'b1;
    tick(2);
    #1 check("prog mode", 16'h0001, {15'h0000, pmode});
    check("prog pc", 16'h0000, {2'h0, pm_addr});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    tick(16);
    @(posedge clk) rst_n <= 1'b1;
    rreg(4'h0, 8'h18);
    rreg(4'hF, 8'h00);
    wreg(4'h2, 8'h10);
    rreg(4'h2, 8'h10);
    $display("test reset done");
    // Port change wake, global enable clear, pins held
    wreg(4'h1, 8'h08);
    pin_o <= 6'($random(seed));
    pin_e <= 6'($random(seed));
    tick(2);
    sleep_now();
    #1 check("sleeping", 16'h0001, {15'h0000, sleeping});
    check("osc off", 16'h0000, {15'h0000, osc});
    check("fetch", {2'h0, pc + 14'h0001}, {2'h0, faddr});
    pin_o <= ~pin_o;
    pin_e <= ~pin_e;
    tick(3);
    #1 check("pins held", {4'h0, ~pin_o, ~pin_e}, {4'h0, opin, ooe});
    rreg(4'h0, 8'h10);
    res_q.push_back({1'b0, pc + 14'h0001});
    @(posedge clk) pchg <= 3'h4;
    wait_sig(0, 8, n);
    $display("test port change wake done");
    // Pending enabled flag turns sleep into a no-operation
    @(posedge clk) wclr <= 1'b1;
    @(posedge clk) wclr <= 1'b0;
    sleep_now();
    tick(2);
    #1 check("nop sleep", 16'h0000, {15'h0000, sleeping});
    rreg(4'h0, 8'h18);
    $display("test nop sleep done");
    // External edge wake with global enable set, port change masked
    wreg(4'h1, 8'h90);
    wreg(4'h2, 8'h50);
    sleep_now();
    @(posedge clk) pchg <= 3'h1;
    tick(10);
    #1 check("masked wake", 16'h0001, {15'h0000, sleeping});
    res_q.push_back({1'b1, 14'h0004});
    @(posedge clk) ext <= 1'b1;
    wait_sig(0, 8, n);
    check("rc wake delay", 16'h0001, {15'h0000, n <= 6});
    $display("test vector wake done");
    // Crystal mode waits for oscillator start-up
    @(posedge clk) ext <= 1'b0;
    wreg(4'h1, 8'h90);
    wreg(4'h2, 8'h52);
    sleep_now();
    res_q.push_back({1'b1, 14'h0004});
    @(posedge clk) ext <= 1'b1;
    wait_sig(0, 1100, n);
    check("start-up delay", 16'h0001, {15'h0000, n >= 1024 && n <= 1032});
    $display("test crystal wake done");
    // A/D wake only with its RC clock, master clear resets
    wreg(4'h1, 8'h00);
    wreg(4'h2, 8'h10);
    wreg(4'h3, 8'h02);
    sleep_now();
    @(posedge clk) adc <= 1'b1;
    @(posedge clk) adc <= 1'b0;
    tick(10);
    #1 check("adc no rc", 16'h0001, {15'h0000, sleeping});
    @(posedge clk) master_clear_pin_n <= 1'b0;
    wait_sig(1, 4, n);
    @(posedge clk) master_clear_pin_n <= 1'b1;
    #1 check("reset awake", 16'h0000, {15'h0000, sleeping});
    wreg(4'h3, 8'h02);
    wreg(4'h2, 8'h18);
    sleep_now();
    res_q.push_back({1'b0, pc + 14'h0001});
    @(posedge clk) adc <= 1'b1;
    @(posedge clk) adc <= 1'b0;
    wait_sig(0, 8, n);
    $display("test adc and master clear done");
    // Watchdog wake while asleep, reset while running
    wreg(4'h3, 8'h00);
    wreg(4'h2, 8'h11);
    sleep_now();
    res_q.push_back({1'b0, pc + 14'h0001});
    wait_sig(0, 100, n);
    rreg(4'h0, 8'h00);
    wait_sig(1, 140, n);
    wreg(4'h2, 8'h10);
    $display("test watchdog done");
    // Serial programming: ID word round trip, memory readout, protection
    pmem <= 14'($random(seed));
    id_val = 14'($random(seed));
    prog_enter();
    pbits(14'h0000, 6, got);
    pbits(14'h0002, 6, got);
    pbits(id_val, 14, got);
    pbits(14'h0004, 6, got);
    pbits(14'h0000, 14, got);
    check("id word", {2'h0, id_val}, {2'h0, got});
    check("data oe", 16'h0001, {15'h0000, pd_oe});
    prog_enter();
    pbits(14'h0004, 6, got);
    pbits(14'h0000, 14, got);
    check("pmem read", {2'h0, pmem}, {2'h0, got});
    @(posedge clk) hv <= 1'b0;
    wreg(4'h2, 8'h30);
    prog_enter();
    pbits(14'h0004, 6, got);
    pbits(14'h0000, 14, got);
    check("protected", 16'h0000, {2'h0, got});
    wr_q.push_back(id_val);
    pbits(14'h0002, 6, got);
    pbits(id_val, 14, got);
    $display("test programming done");
    tick(4);
    stop_test();
  end
endmodule
